// [hdl/cis_core.sv]
// Inherent-op sequencer: fetches opcodes and runs their bus cycles.
// Assumes an asynchronous memory bus; one bus cycle per E period, data in
// sampled at the falling edge of E, pins synchronised here.
// Function
// (RULE1) Opcode 07 copies flags into A, flags unchanged, two cycles.
// (RULE2) Zero-or-minus check sets N and Z, clears V and C, memory or A/B.
// (RULE3) Opcode 30 loads X with stack+1; third cycle reads at old stack.
// (RULE4) Prefixed 30 loads Y with stack+1; fourth cycle at stack pointer.
// (RULE5) Opcode 35 loads stack pointer with X-1 in three cycles.
// (RULE6) Prefixed 35 loads stack pointer with Y-1 in four cycles.
// (RULE7) Opcode 3E stacks in 12 cycles, idles until interrupt, fetches vector.
// (RULE8) Opcode 00 counts the address bus until reset, test mode only.
// (RULE9) Direct operand is an address with high byte zero.
// (RULE10) Indexed offset is unsigned 0..255, added to the index register.
// (RULE11) Branch offset is signed, relative to the byte after it.
// (RULE12) Long addresses come high byte first, then low byte.
// (RULE13) Sixteen-bit immediate data comes high byte first.
// (RULE14) Bit mask selects which bits a bit operation changes.
// (RULE15) Two-cycle ops fetch, then read next address and discard it.
// (RULE16) Three-cycle ops fetch, dummy-read next, then dummy-read FFFF; opcode 30 and pushes of A/B use the stack pointer in the third cycle.
// (RULE17) Prefixed four-cycle ops: prefix, opcode, next, then FFFF reads; prefixed 30 reads the stack pointer instead.
// (RULE18) Push X writes low at stack, high at stack-1; push A/B once.
// (RULE19) Push Y: prefix, opcode, dummy read, then low and high writes.
// (RULE20) Pull A/B: fetch, dummy, dummy at stack, read at stack+1.
// (RULE21) Pull X: dummy at stack, high at stack+1, low at stack+2.
// (RULE22) Exchanges swap D with X or Y at once, flags unchanged.
// (RULE23) Stack decrements after each push, increments before each pull.
`include "cis_map.svh"

module cis_core #(
  parameter int E_DIV = `CIS_E_DIV
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] data_in,
  input wire logic irq_n,
  input wire logic test_mode,
  output logic [15:0] bus_addr,
  output logic [7:0] bus_dout,
  output logic bus_rw,
  output logic data_oe_n,
  output logic bus_e,
  output cis_pkg::cis_phase_t seq_phase,
  output cis_pkg::cis_regs_t cpu_regs
);
  timeunit 1ns;
  timeprecision 1ns;

  // Divider needs room for a synchronised sample before the falling edge
  if (E_DIV < 4 || E_DIV > 256 || (E_DIV % 2) != 0) begin
    $error("cis_core: E_DIV must be even and within 4..256");
  end

  localparam logic [7:0] DIV_LAST = 8'(E_DIV - 1);
  localparam logic [7:0] DIV_HALF = 8'(E_DIV / 2);

  cis_pkg::cis_state_t s_r, s_nxt;
  logic rst_sync1_r, rst_sync2_r;

  // Order in which the wait opcode stacks its nine bytes
  function automatic logic [7:0] stack_byte(input cis_pkg::cis_regs_t r,
                                            input logic [3:0] idx);
    case (idx)
      4'h0: stack_byte = r.pc[7:0];
      4'h1: stack_byte = r.pc[15:8];
      4'h2: stack_byte = r.index_y[7:0];
      4'h3: stack_byte = r.index_y[15:8];
      4'h4: stack_byte = r.index_x[7:0];
      4'h5: stack_byte = r.index_x[15:8];
      4'h6: stack_byte = r.acc_a;
      4'h7: stack_byte = r.acc_b;
      default: stack_byte = r.flag_register;
    endcase
  endfunction

  function automatic logic [7:0] zm_flags(input logic [7:0] f,
                                          input logic neg, input logic zero,
                                          input logic clr_c);
    zm_flags = f;
    zm_flags[`CIS_FLAG_N] = neg;
    zm_flags[`CIS_FLAG_Z] = zero;
    zm_flags[`CIS_FLAG_V] = 1'b0;
    if (clr_c) begin
      zm_flags[`CIS_FLAG_C] = 1'b0;
    end
  endfunction

  // (RULE9) High byte forced to zero
  function automatic logic [15:0] dir_addr(input logic [7:0] dd);
    dir_addr = {8'h00, dd};
  endfunction

  // (RULE10) Unsigned offset plus index
  function automatic logic [15:0] idx_addr(input logic [15:0] base,
                                           input logic [7:0] ff);
    idx_addr = base + {8'h00, ff};
  endfunction

  // (RULE11) Signed offset from the following byte
  function automatic logic [15:0] rel_addr(input logic [15:0] next_pc,
                                           input logic [7:0] rr);
    rel_addr = next_pc + {{8{rr[7]}}, rr};
  endfunction

  // (RULE14) Only masked bits change
  function automatic logic [7:0] mask_apply(input logic [7:0] v,
                                            input logic [7:0] mm,
                                            input logic set);
    mask_apply = set ? (v | mm) : (v & ~mm);
  endfunction

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync1_r <= 1'b0;
      rst_sync2_r <= 1'b0;
    end else begin
      rst_sync1_r <= 1'b1;
      rst_sync2_r <= rst_sync1_r;
    end
  end

  always_comb begin
    logic tick;
    logic fin;
    logic [15:0] index_sel;
    tick = 1'b0;
    fin = 1'b0;
    index_sel = 16'h0000;
    s_nxt = s_r;
    s_nxt.din1 = data_in;
    s_nxt.din2 = s_r.din1;
    s_nxt.irq1 = ~irq_n;
    s_nxt.irq2 = s_r.irq1;
    s_nxt.tm1 = test_mode;
    s_nxt.tm2 = s_r.tm1;
    tick = (s_r.div == DIV_LAST);
    s_nxt.div = tick ? 8'h00 : s_r.div + 8'h01;
    s_nxt.e = (s_nxt.div >= DIV_HALF);
    index_sel = s_r.pre ? s_r.regs.index_y : s_r.regs.index_x;
    if (tick) begin
      s_nxt.bus.rw = 1'b1;
      s_nxt.k = s_r.k + 4'h1;
      case (s_r.phase)
        cis_pkg::CIS_PH_FETCH: begin
          s_nxt.regs.pc = s_r.regs.pc + 16'h0001;
          s_nxt.bus.addr = s_r.regs.pc + 16'h0001;
          // (RULE17) Prefix byte, then the second opcode byte
          if (!s_r.pre && s_r.din2 == `CIS_OP_PREFIX) begin
            s_nxt.pre = 1'b1;
          end else begin
            s_nxt.op = s_r.din2;
            s_nxt.k = 4'h2;
            s_nxt.phase = cis_pkg::CIS_PH_EXEC;
            // (RULE8) Counting mode only with test mode strapped
            if (s_r.din2 == `CIS_OP_BUS_COUNT && s_r.tm2 && !s_r.pre) begin
              s_nxt.phase = cis_pkg::CIS_PH_COUNT;
            end
          end
        end
        cis_pkg::CIS_PH_COUNT: begin
          // (RULE8) Never leaves until reset
          s_nxt.bus.addr = s_r.bus.addr + 16'h0001;
        end
        cis_pkg::CIS_PH_WAIT: begin
          // (RULE7) Idle whole E cycles until interrupt
          if (s_r.irq2 && !s_r.regs.flag_register[`CIS_FLAG_I]) begin
            s_nxt.phase = cis_pkg::CIS_PH_VEC;
            s_nxt.k = 4'hD;
            s_nxt.bus.addr = `CIS_WAIT_VEC;
          end
        end
        cis_pkg::CIS_PH_VEC: begin
          // (RULE7) Two vector cycles
          if (s_r.k == 4'hD) begin
            s_nxt.tmp[15:8] = s_r.din2;
            s_nxt.bus.addr = `CIS_WAIT_VEC + 16'h0001;
          end else begin
            s_nxt.regs.pc = {s_r.tmp[15:8], s_r.din2};
            s_nxt.regs.flag_register[`CIS_FLAG_I] = 1'b1;
            fin = 1'b1;
          end
        end
        default: begin
          // (RULE15) The cycle after the opcode fetch already read the next address
          case (s_r.op)
            // (RULE1) Flags to A
            `CIS_OP_FLAGS_TO_ACC_A: begin
              s_nxt.regs.acc_a = s_r.regs.flag_register;
              fin = 1'b1;
            end
            // (RULE2) Accumulator checks
            `CIS_OP_CHECK_A: begin
              s_nxt.regs.flag_register = zm_flags(s_r.regs.flag_register,
                s_r.regs.acc_a[7], s_r.regs.acc_a == 8'h00, 1'b1);
              fin = 1'b1;
            end
            `CIS_OP_CHECK_B: begin
              s_nxt.regs.flag_register = zm_flags(s_r.regs.flag_register,
                s_r.regs.acc_b[7], s_r.regs.acc_b == 8'h00, 1'b1);
              fin = 1'b1;
            end
            `CIS_OP_STACK_TO_INDEX: begin
              if (s_r.k == 4'h2) begin
                // (RULE3) Dummy read at the unchanged stack pointer
                s_nxt.bus.addr = s_r.regs.stack_pointer;
              end else begin
                // (RULE4) Stack plus one into X or Y
                if (s_r.pre) begin
                  s_nxt.regs.index_y = s_r.regs.stack_pointer + 16'h0001;
                end else begin
                  s_nxt.regs.index_x = s_r.regs.stack_pointer + 16'h0001;
                end
                fin = 1'b1;
              end
            end
            `CIS_OP_INDEX_TO_STACK: begin
              // (RULE16) Third cycle reads FFFF
              if (s_r.k == 4'h2) begin
                s_nxt.bus.addr = `CIS_DUMMY_ADDR;
              end else begin
                // (RULE5) (RULE6) Index minus one into stack
                s_nxt.regs.stack_pointer = index_sel - 16'h0001;
                fin = 1'b1;
              end
            end
            `CIS_OP_SWAP_D: begin
              if (s_r.k == 4'h2) begin
                s_nxt.bus.addr = `CIS_DUMMY_ADDR;
              end else begin
                // (RULE22) Both moves in one edge
                {s_nxt.regs.acc_a, s_nxt.regs.acc_b} = index_sel;
                if (s_r.pre) begin
                  s_nxt.regs.index_y = {s_r.regs.acc_a, s_r.regs.acc_b};
                end else begin
                  s_nxt.regs.index_x = {s_r.regs.acc_a, s_r.regs.acc_b};
                end
                fin = 1'b1;
              end
            end
            `CIS_OP_PUSH_A, `CIS_OP_PUSH_B: begin
              if (s_r.k == 4'h2) begin
                s_nxt.bus.addr = s_r.regs.stack_pointer;
                s_nxt.bus.dout = s_r.op[0] ? s_r.regs.acc_b : s_r.regs.acc_a;
                s_nxt.bus.rw = 1'b0;
              end else begin
                // (RULE23) Decrement after the byte
                s_nxt.regs.stack_pointer = s_r.regs.stack_pointer - 16'h0001;
                fin = 1'b1;
              end
            end
            `CIS_OP_PUSH_INDEX: begin
              // (RULE18) (RULE19) Low byte first, then high at stack-1
              if (s_r.k == 4'h2) begin
                s_nxt.bus.addr = s_r.regs.stack_pointer;
                s_nxt.bus.dout = index_sel[7:0];
                s_nxt.bus.rw = 1'b0;
              end else begin
                s_nxt.regs.stack_pointer = s_r.regs.stack_pointer - 16'h0001;
                if (s_r.k == 4'h3) begin
                  s_nxt.bus.addr = s_nxt.regs.stack_pointer;
                  s_nxt.bus.dout = index_sel[15:8];
                  s_nxt.bus.rw = 1'b0;
                end else begin
                  fin = 1'b1;
                end
              end
            end
            `CIS_OP_PULL_A, `CIS_OP_PULL_B, `CIS_OP_PULL_INDEX: begin
              // (RULE20) (RULE21) Dummy at stack, then increment and read
              if (s_r.k == 4'h2) begin
                s_nxt.bus.addr = s_r.regs.stack_pointer;
              end else begin
                if (s_r.k == 4'h4 && s_r.op == `CIS_OP_PULL_INDEX) begin
                  s_nxt.tmp[15:8] = s_r.din2;
                end
                if (s_r.k == 4'h3 || (s_r.k == 4'h4 &&
                    s_r.op == `CIS_OP_PULL_INDEX)) begin
                  // (RULE23) Increment before the byte
                  s_nxt.regs.stack_pointer = s_r.regs.stack_pointer + 16'h0001;
                  s_nxt.bus.addr = s_nxt.regs.stack_pointer;
                end else begin
                  if (s_r.op == `CIS_OP_PULL_A) begin
                    s_nxt.regs.acc_a = s_r.din2;
                  end else if (s_r.op == `CIS_OP_PULL_B) begin
                    s_nxt.regs.acc_b = s_r.din2;
                  end else begin
                    s_nxt.regs.index_x = {s_r.tmp[15:8], s_r.din2};
                  end
                  fin = 1'b1;
                end
              end
            end
            `CIS_OP_WAIT_IRQ: begin
              // (RULE7) Nine stacked bytes, one dummy, then idle
              if (s_r.k == 4'h2) begin
                s_nxt.bus.addr = s_r.regs.stack_pointer;
                s_nxt.bus.dout = stack_byte(s_r.regs, 4'h0);
                s_nxt.bus.rw = 1'b0;
              end else if (s_r.k <= 4'hB) begin
                s_nxt.regs.stack_pointer = s_r.regs.stack_pointer - 16'h0001;
                s_nxt.bus.addr = s_nxt.regs.stack_pointer;
                if (s_r.k <= 4'hA) begin
                  s_nxt.bus.dout = stack_byte(s_r.regs, s_r.k - 4'h2);
                  s_nxt.bus.rw = 1'b0;
                end
              end else begin
                s_nxt.phase = cis_pkg::CIS_PH_WAIT;
              end
            end
            `CIS_OP_CHECK_LONG, `CIS_OP_CHECK_INDEXED: begin
              case (s_r.k)
                4'h2: begin
                  // (RULE12) High byte first
                  s_nxt.tmp[15:8] = s_r.din2;
                  s_nxt.tmp[7:0] = s_r.din2;
                  s_nxt.regs.pc = s_r.regs.pc + 16'h0001;
                  s_nxt.bus.addr = s_r.op[4] ? s_nxt.regs.pc : `CIS_DUMMY_ADDR;
                end
                4'h3: begin
                  if (s_r.op[4]) begin
                    s_nxt.regs.pc = s_r.regs.pc + 16'h0001;
                    s_nxt.bus.addr = {s_r.tmp[15:8], s_r.din2};
                  end else begin
                    s_nxt.bus.addr = idx_addr(index_sel, s_r.tmp[7:0]);
                  end
                end
                4'h4: begin
                  // (RULE2) Memory operand minus zero
                  s_nxt.regs.flag_register = zm_flags(s_r.regs.flag_register,
                    s_r.din2[7], s_r.din2 == 8'h00, 1'b1);
                  s_nxt.bus.addr = `CIS_DUMMY_ADDR;
                end
                4'h5: s_nxt.bus.addr = `CIS_DUMMY_ADDR;
                default: fin = 1'b1;
              endcase
            end
            `CIS_OP_LOAD_D_IMM: begin
              // (RULE13) High byte into A first
              s_nxt.regs.pc = s_r.regs.pc + 16'h0001;
              if (s_r.k == 4'h2) begin
                s_nxt.regs.acc_a = s_r.din2;
                s_nxt.bus.addr = s_nxt.regs.pc;
              end else begin
                s_nxt.regs.acc_b = s_r.din2;
                s_nxt.regs.flag_register = zm_flags(s_r.regs.flag_register,
                  s_r.regs.acc_a[7], {s_r.regs.acc_a, s_r.din2} == 16'h0000,
                  1'b0);
                fin = 1'b1;
              end
            end
            `CIS_OP_BRANCH: begin
              if (s_r.k == 4'h2) begin
                s_nxt.tmp[7:0] = s_r.din2;
                s_nxt.regs.pc = s_r.regs.pc + 16'h0001;
                s_nxt.bus.addr = `CIS_DUMMY_ADDR;
              end else begin
                s_nxt.regs.pc = rel_addr(s_r.regs.pc, s_r.tmp[7:0]);
                fin = 1'b1;
              end
            end
            `CIS_OP_BIT_SET_DIR, `CIS_OP_BIT_CLR_DIR: begin
              case (s_r.k)
                4'h2: begin
                  s_nxt.tmp[7:0] = s_r.din2;
                  s_nxt.regs.pc = s_r.regs.pc + 16'h0001;
                  s_nxt.bus.addr = s_nxt.regs.pc;
                end
                4'h3: begin
                  s_nxt.tmp[15:8] = s_r.din2;
                  s_nxt.regs.pc = s_r.regs.pc + 16'h0001;
                  s_nxt.bus.addr = dir_addr(s_r.tmp[7:0]);
                end
                4'h4: begin
                  s_nxt.dat = mask_apply(s_r.din2, s_r.tmp[15:8], ~s_r.op[0]);
                  s_nxt.bus.addr = `CIS_DUMMY_ADDR;
                end
                4'h5: begin
                  s_nxt.bus.addr = dir_addr(s_r.tmp[7:0]);
                  s_nxt.bus.dout = s_r.dat;
                  s_nxt.bus.rw = 1'b0;
                end
                default: begin
                  s_nxt.regs.flag_register = zm_flags(s_r.regs.flag_register,
                    s_r.dat[7], s_r.dat == 8'h00, 1'b0);
                  fin = 1'b1;
                end
              endcase
            end
            default: fin = 1'b1;
          endcase
        end
      endcase
      if (fin) begin
        s_nxt.phase = cis_pkg::CIS_PH_FETCH;
        s_nxt.pre = 1'b0;
        s_nxt.bus.addr = s_nxt.regs.pc;
        s_nxt.bus.rw = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync2_r) begin
    if (!rst_sync2_r) begin
      s_r <= '0;
      s_r.phase <= cis_pkg::CIS_PH_FETCH;
      s_r.regs.pc <= `CIS_RST_PC;
      s_r.regs.stack_pointer <= `CIS_RST_STACK;
      s_r.regs.flag_register <= `CIS_RST_FLAGS;
      s_r.bus.addr <= `CIS_RST_PC;
      s_r.bus.rw <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus_addr = s_r.bus.addr;
  assign bus_dout = s_r.bus.dout;
  assign bus_rw = s_r.bus.rw;
  // Drives only during write cycles
  assign data_oe_n = s_r.bus.rw;
  assign bus_e = s_r.e;
  assign seq_phase = s_r.phase;
  assign cpu_regs = s_r.regs;

endmodule

// [hdl/cis_map.svh]
// Constants of the inherent-op sequencer: opcodes, flag bits, reset values
// and bus timing. Assumes a 20 MHz core clock.
`ifndef CIS_MAP_SVH
`define CIS_MAP_SVH

`define CIS_CORE_MHZ 20
`define CIS_E_PERIOD_NS 500
`define CIS_E_DIV ((`CIS_E_PERIOD_NS * `CIS_CORE_MHZ) / 1000)

`define CIS_RST_PC 16'h0000
`define CIS_RST_STACK 16'h00FF
`define CIS_RST_FLAGS 8'hD0
`define CIS_WAIT_VEC 16'hFFF0
`define CIS_DUMMY_ADDR 16'hFFFF

`define CIS_FLAG_I 4
`define CIS_FLAG_N 3
`define CIS_FLAG_Z 2
`define CIS_FLAG_V 1
`define CIS_FLAG_C 0

`define CIS_OP_PREFIX 8'h18
`define CIS_OP_BUS_COUNT 8'h00
`define CIS_OP_FLAGS_TO_ACC_A 8'h07
`define CIS_OP_CHECK_A 8'h4D
`define CIS_OP_CHECK_B 8'h5D
`define CIS_OP_CHECK_LONG 8'h7D
`define CIS_OP_CHECK_INDEXED 8'h6D
`define CIS_OP_STACK_TO_INDEX 8'h30
`define CIS_OP_INDEX_TO_STACK 8'h35
`define CIS_OP_WAIT_IRQ 8'h3E
`define CIS_OP_SWAP_D 8'h8F
`define CIS_OP_PUSH_A 8'h36
`define CIS_OP_PUSH_B 8'h37
`define CIS_OP_PUSH_INDEX 8'h3C
`define CIS_OP_PULL_A 8'h32
`define CIS_OP_PULL_B 8'h33
`define CIS_OP_PULL_INDEX 8'h38
`define CIS_OP_LOAD_D_IMM 8'hCC
`define CIS_OP_BRANCH 8'h20
`define CIS_OP_BIT_SET_DIR 8'h14
`define CIS_OP_BIT_CLR_DIR 8'h15

`endif

// [hdl/cis_pkg.sv]
// Types of the inherent-op sequencer.
// Assumes cis_map.svh supplies all numeric constants.
package cis_pkg;

  typedef enum logic [2:0] {
    CIS_PH_FETCH,
    CIS_PH_EXEC,
    CIS_PH_WAIT,
    CIS_PH_VEC,
    CIS_PH_COUNT
  } cis_phase_t;

  typedef struct packed {
    logic [7:0] acc_a;
    logic [7:0] acc_b;
    logic [7:0] flag_register;
    logic [15:0] index_x;
    logic [15:0] index_y;
    logic [15:0] stack_pointer;
    logic [15:0] pc;
  } cis_regs_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] dout;
    logic rw;
  } cis_bus_t;

  typedef struct packed {
    cis_phase_t phase;
    logic pre;
    logic [7:0] op;
    logic [3:0] k;
    logic [15:0] tmp;
    logic [7:0] dat;
    cis_regs_t regs;
    cis_bus_t bus;
    logic e;
    logic [7:0] div;
    logic [7:0] din1;
    logic [7:0] din2;
    logic irq1;
    logic irq2;
    logic tm1;
    logic tm2;
  } cis_state_t;

endpackage

// [verification/cis_core_assertions.sv]
// Checker of the inherent-op sequencer's bus cycles, bound to cis_core.
// Assumes only the core's ports and its single clock domain.
module cis_core_assertions #(
  parameter int E_DIV = 10
) (
  input logic core_clk,
  input logic rst_n,
  input logic [7:0] data_in,
  input logic irq_n,
  input logic test_mode,
  input logic [15:0] bus_addr,
  input logic [7:0] bus_dout,
  input logic bus_rw,
  input logic data_oe_n,
  input logic bus_e,
  input cis_pkg::cis_phase_t seq_phase,
  input cis_pkg::cis_regs_t cpu_regs
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] hi_cnt;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // Length of the E-high half, cleared while E is low
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hi_cnt <= 8'h00;
    end else begin
      hi_cnt <= bus_e ? hi_cnt + 8'h01 : 8'h00;
    end
  end
  sequence s_cycle_edge;
    $fell(bus_e);
  endsequence
  sequence s_write_after_write;
    $fell(bus_e) && !bus_rw && !$past(bus_rw);
  endsequence
  AST_BUS_STANDS: assert property (
    !$stable({bus_addr, bus_rw}) |-> s_cycle_edge)
    else $error("bus address or direction moved inside a cycle");
  AST_DOUT_STANDS: assert property (
    !bus_rw && !$fell(bus_e) |-> $stable(bus_dout))
    else $error("write data moved inside a write cycle");
  AST_OE_FOLLOWS_RW: assert property (
    data_oe_n == bus_rw)
    else $error("data pin enable disagrees with direction");
  AST_E_HIGH_LEN: assert property (
    s_cycle_edge |-> hi_cnt == 8'(E_DIV / 2))
    else $error("E high half has the wrong length");
  AST_PUSH_DESC: assert property (
    s_write_after_write |-> bus_addr == $past(bus_addr) - 16'h0001)
    else $error("back-to-back stack writes not descending by one");
  AST_COUNT_INC: assert property (
    s_cycle_edge ##0 seq_phase == cis_pkg::CIS_PH_COUNT
    ##0 $past(seq_phase) == cis_pkg::CIS_PH_COUNT
    |-> bus_rw && bus_addr == $past(bus_addr) + 16'h0001)
    else $error("counting address did not step by one");
  AST_COUNT_HOLD: assert property (
    seq_phase == cis_pkg::CIS_PH_COUNT |=> seq_phase == cis_pkg::CIS_PH_COUNT)
    else $error("bus count left before reset");
  AST_WAIT_IDLE: assert property (
    seq_phase == cis_pkg::CIS_PH_WAIT && $past(seq_phase) ==
    cis_pkg::CIS_PH_WAIT |-> bus_rw && $stable(bus_addr))
    else $error("idle wait cycle not a read at a fixed address");
  AST_WAIT_MASKED: assert property (
    seq_phase == cis_pkg::CIS_PH_WAIT && cpu_regs.flag_register[4]
    |=> seq_phase == cis_pkg::CIS_PH_WAIT)
    else $error("wait ended while interrupts were masked");
endmodule

bind cis_core cis_core_assertions #(.E_DIV(E_DIV)) u_chk (
  .core_clk(core_clk), .rst_n(rst_n), .data_in(data_in), .irq_n(irq_n),
  .test_mode(test_mode), .bus_addr(bus_addr), .bus_dout(bus_dout),
  .bus_rw(bus_rw), .data_oe_n(data_oe_n), .bus_e(bus_e),
  .seq_phase(seq_phase), .cpu_regs(cpu_regs));

// [verification/cis_mem_model.sv]
// Memory on the far side of the core's bus, 64K bytes, zero filled.
// Assumes read data may follow the address combinationally.
module cis_mem_model (
  input logic core_clk,
  input logic [15:0] bus_addr,
  input logic [7:0] bus_dout,
  input logic bus_rw,
  input logic data_oe_n,
  input logic bus_e,
  output logic [7:0] data_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:65535];
  initial foreach (mem[i]) mem[i] = 8'h00;
  // While the core drives the pins, show a moving pattern, never stale data
  assign data_in = data_oe_n ? mem[bus_addr] : ~bus_addr[7:0];
  // Writes taken in the E-high half, when address and data have settled
  always @(posedge core_clk) begin
    if (bus_e && !bus_rw) begin
      mem[bus_addr] <= bus_dout;
    end
  end
endmodule

// [verification/tb_cis_core.sv]
// Bench of the inherent-op sequencer: one program run, then two opcode 00 runs, against the memory
module tb_cis_core;
  timeunit 1ns;
  timeprecision 1ns;
  typedef logic [27:0] cis_trace_t[$];
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic irq_n = 1'b1;
  logic test_mode = 1'b0;
  logic [7:0] data_in;
  logic [15:0] bus_addr;
  logic [7:0] bus_dout;
  logic bus_rw;
  logic data_oe_n;
  logic bus_e;
  cis_pkg::cis_phase_t seq_phase;
  cis_pkg::cis_regs_t cpu_regs;
  int bad_count = 0;
  int n_compared = 0;
  always #25 core_clk = ~core_clk;
  cis_core #(.E_DIV(4)) dut (.core_clk(core_clk), .rst_n(rst_n),
    .data_in(data_in), .irq_n(irq_n), .test_mode(test_mode),
    .bus_addr(bus_addr), .bus_dout(bus_dout), .bus_rw(bus_rw),
    .data_oe_n(data_oe_n), .bus_e(bus_e), .seq_phase(seq_phase),
    .cpu_regs(cpu_regs));
  cis_mem_model mem_i (.core_clk(core_clk), .bus_addr(bus_addr),
    .bus_dout(bus_dout), .bus_rw(bus_rw), .data_oe_n(data_oe_n),
    .bus_e(bus_e), .data_in(data_in));
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp,
                      input string what);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // Bounded wait for the middle of the next bus cycle (rise of E)
  task automatic wait_start();
    logic p;
    p = bus_e;
    for (int n = 0; n < 40; n++) begin
      @(posedge core_clk);
      #1;
      if (bus_e === 1'b1 && p === 1'b0) return;
      p = bus_e;
    end
    bad_count++;
    $display("ERROR %0t no bus cycle seen", $time);
    report_and_stop();
  endtask
  // Entry: data [27:20], direction [16], address [15:0]
  task automatic trace(input cis_trace_t t);
    foreach (t[i]) begin
      wait_start();
      cmp16(bus_addr, t[i][15:0], "address");
      cmp8({7'h00, bus_rw}, {7'h00, t[i][16]}, "direction");
      if (!t[i][16]) begin
        cmp8(bus_dout, t[i][27:20], "write data");
      end
    end
  endtask
  task automatic put(input logic [15:0] a, input logic [7:0] b[$]);
    foreach (b[i]) mem_i.mem[a + 16'(i)] = b[i];
  endtask
  task automatic do_reset(input logic tm);
    rst_n = 1'b0;
    test_mode = tm;
    repeat (5) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
  endtask
  task automatic s_transfers();
    trace('{28'h10000, 28'h10001, 28'h10001, 28'h10002, 28'h10002,
      28'h10003, 28'h10003, 28'h10004, 28'h100FF, 28'h10004, 28'h10005,
      28'h10006, 28'h100FF, 28'h10006});
    cmp8(cpu_regs.acc_a, 8'hD0, "acc a");
    cmp8(cpu_regs.flag_register, 8'hD4, "flags");
    cmp16(cpu_regs.index_x, 16'h0100, "index x");
    cmp16(cpu_regs.index_y, 16'h0100, "index y");
  endtask
  task automatic s_stack();
    trace('{28'h10007, 28'h10008, 28'h10009, 28'h1000A, 28'h12000FF,
      28'h1000A, 28'h1000B, 28'h00000FE, 28'h01000FD, 28'h1000B,
      28'h1000C, 28'h1000D, 28'h00000FC, 28'h01000FB, 28'h1000D,
      28'h1000E, 28'h100FA, 28'h100FB, 28'h1000E, 28'h1000F, 28'h100FB,
      28'h100FC, 28'h100FD, 28'h1000F});
    cmp8(cpu_regs.acc_a, 8'h01, "acc a");
    cmp8(cpu_regs.acc_b, 8'h34, "acc b");
    cmp16(cpu_regs.index_x, 16'h0001, "index x");
    cmp16(cpu_regs.stack_pointer, 16'h00FD, "stack");
  endtask
  task automatic s_swaps();
    trace('{28'h10010, 28'h1FFFF, 28'h10010, 28'h10011, 28'h1FFFF,
      28'h10011, 28'h10012, 28'h10013, 28'h1FFFF, 28'h10013, 28'h10014,
      28'h10015, 28'h1FFFF, 28'h10015});
    cmp8(cpu_regs.acc_a, 8'h01, "acc a");
    cmp8(cpu_regs.acc_b, 8'h00, "acc b");
    cmp16(cpu_regs.index_x, 16'h0134, "index x");
    cmp16(cpu_regs.index_y, 16'h0001, "index y");
    cmp16(cpu_regs.stack_pointer, 16'h0000, "stack");
    cmp8(cpu_regs.flag_register, 8'hD0, "flags");
  endtask
  task automatic s_operands();
    trace('{28'h10016, 28'h10017, 28'h100F0, 28'h1FFFF, 28'h1FFFF,
      28'h10018});
    cmp8(cpu_regs.flag_register, 8'hD8, "flags");
    trace('{28'h10019, 28'h1FFFF, 28'h10224, 28'h1FFFF, 28'h1FFFF,
      28'h1001A, 28'h1001B, 28'h1001C, 28'h1FFFF, 28'h10011, 28'h1FFFF,
      28'h1FFFF, 28'h1001D, 28'h1001E, 28'h1001F, 28'h10040, 28'h1FFFF,
      28'hAF00040, 28'h10020, 28'h10021, 28'h10022, 28'h10041,
      28'h1FFFF, 28'h0F00041, 28'h10023, 28'h10024, 28'h1FFFF,
      28'h1FFA5});
    cmp8(cpu_regs.flag_register, 8'hD0, "flags");
  endtask
  task automatic s_wait();
    trace('{28'h1FFA6, 28'hA600000, 28'hFF0FFFF, 28'h010FFFE,
      28'h000FFFD, 28'h340FFFC, 28'h010FFFB, 28'h010FFFA, 28'h000FFF9,
      28'hD00FFF8, 28'h1FFF7});
    irq_n = 1'b0;
    trace('{28'h1FFF7, 28'h1FFF7, 28'h1FFF7});
    cmp8(8'(seq_phase), 8'(cis_pkg::CIS_PH_WAIT), "phase");
    cmp16(cpu_regs.stack_pointer, 16'hFFF7, "stack");
    irq_n = 1'b1;
  endtask
  task automatic s_bus_count();
    put(16'h0000, '{8'h00});
    do_reset(1'b1);
    trace('{28'h10000, 28'h10001, 28'h10002, 28'h10003});
    cmp8(8'(seq_phase), 8'(cis_pkg::CIS_PH_COUNT), "phase");
    // Outside test mode the same opcode is only a two-cycle no-op
    do_reset(1'b0);
    trace('{28'h10000, 28'h10001, 28'h10001, 28'h10002});
  endtask
  initial begin
    #5;
    put(16'h0000, '{8'h07, 8'h4D, 8'h5D, 8'h30, 8'h18, 8'h30, 8'hCC,
      8'h12, 8'h34, 8'h36, 8'h3C, 8'h18, 8'h3C, 8'h32, 8'h38, 8'h35,
      8'h8F, 8'h18, 8'h8F, 8'h18, 8'h35, 8'h7D, 8'h00, 8'hF0, 8'h6D,
      8'hF0, 8'h18, 8'h6D, 8'h10, 8'h14, 8'h40, 8'h0F, 8'h15, 8'h41,
      8'hF0, 8'h20, 8'h80});
    put(16'h0040, '{8'hA0, 8'hFF});
    put(16'h00F0, '{8'h80});
    put(16'hFFA5, '{8'h3E});
    do_reset(1'b0);
    s_transfers();
    s_stack();
    s_swaps();
    s_operands();
    s_wait();
    s_bus_count();
    report_and_stop();
  end
endmodule
